// ### hw/mcu_alu.sv
// Eight-bit arithmetic and logic unit with overflow, carry, half-carry and zero outputs.
`timescale 1ns/1ps
`default_nettype none
module mcu_alu
	import mcu_decoder_pkg::*;
(
	input  wire logic [7:0] a,
	input  wire logic [7:0] b,
	input  wire logic       cin,
	input  alu_op_t         op,
	output logic [7:0]      y,
	output flags_t          fl
);

	logic [7:0] bb;
	logic       ci;
	logic [8:0] sum;
	logic [4:0] half;

	// Subtraction is a plus the inverted b plus one, so carry means no borrow.
	always_comb begin
		bb   = (op == ALU_SUB) ? ~b : b;
		ci   = (op == ALU_SUB) ? 1'b1 : cin;
		sum  = {1'b0, a} + {1'b0, bb} + {8'h00, ci};
		half = {1'b0, a[3:0]} + {1'b0, bb[3:0]} + {4'h0, ci};
		fl   = '0;
		case (op)
			ALU_ADD, ALU_SUB: begin
				y     = sum[7:0];
				fl.c  = sum[8];
				fl.hc   = half[4];
				fl.wrap = (a[7] == bb[7]) && (sum[7] != a[7]);
			end
			ALU_AND: y = a & b;
			ALU_OR:  y = a | b;
			ALU_XOR: y = a ^ b;
			// Pass hands cin through as carry, for adjust results.
			default: begin
				y    = b;
				fl.c = cin;
			end
		endcase
		fl.z = (y == 8'h00);
	end

endmodule
`default_nettype wire

// ### hw/mcu_decoder_pkg.sv
// Shared types, register map, reset values and opcode patterns of the instruction decoder.
package mcu_decoder_pkg;

	typedef enum logic [1:0] {
		PH_DECODE  = 2'b00,
		PH_READ    = 2'b01,
		PH_PROCESS = 2'b10,
		PH_WRITE   = 2'b11
	} q_phase_t;

	typedef enum logic [1:0] {
		ST_EXEC = 2'b00,
		ST_NOP  = 2'b01,
		ST_PROG = 2'b10
	} exec_state_t;

	typedef enum logic [2:0] {
		ALU_ADD  = 3'b000,
		ALU_SUB  = 3'b001,
		ALU_AND  = 3'b010,
		ALU_OR   = 3'b011,
		ALU_XOR  = 3'b100,
		ALU_PASS = 3'b101
	} alu_op_t;

	typedef struct packed {
		logic wrap;
		logic z;
		logic hc;
		logic c;
	} flags_t;

	localparam logic [7:0]  REG_CTRL    = 8'h00;
	localparam logic [7:0]  REG_ACC     = 8'h04;
	localparam logic [7:0]  REG_STATUS  = 8'h08;
	localparam logic [7:0]  REG_PC      = 8'h0C;
	localparam logic [7:0]  REG_BANK    = 8'h10;
	localparam logic [7:0]  REG_PROD    = 8'h14;
	localparam int          STAT_IRQ_DIS = 4;
	localparam int          STAT_PROG   = 5;
	localparam logic [1:0]  RESP_OKAY   = 2'h0;
	localparam logic [1:0]  RESP_SLVERR = 2'h2;

	localparam logic        RUN_RST     = 1'b0;
	localparam logic [7:0]  ACC_RST     = 8'h00;
	localparam logic [7:0]  BANK_RST    = 8'h00;
	localparam logic [7:0]  LATH_RST    = 8'h00;
	localparam logic [15:0] PC_RST      = 16'h0000;
	localparam logic [3:0]  FLAGS_RST   = 4'h0;
	localparam logic        IRQ_DIS_RST = 1'b1;

	localparam logic [1:0]  NOPS_BRANCH    = 2'h1;
	localparam logic [1:0]  NOPS_SKIP      = 2'h1;
	localparam logic [1:0]  NOPS_TBL_PC_LOW = 2'h2;

	localparam logic [15:0] OP_NOP    = 16'h0000;
	localparam logic [15:0] OP_RETURN = 16'h0002;
	localparam logic [15:0] OP_IRQ_RET   = 16'h0005;
	localparam logic [15:0] OP_ADD_LIT   = 16'hB1??;
	localparam logic [15:0] OP_LIT_SUB   = 16'hB2??;
	localparam logic [15:0] OP_OR_LIT    = 16'hB3??;
	localparam logic [15:0] OP_XOR_LIT   = 16'hB4??;
	localparam logic [15:0] OP_AND_LIT   = 16'hB5??;
	localparam logic [15:0] OP_RET_LIT   = 16'hB6??;
	localparam logic [15:0] OP_LONG_CALL = 16'hB7??;
	localparam logic [15:0] OP_LOAD_LIT  = 16'hB0??;
	localparam logic [15:0] OP_BANK_LO   = 16'hB8??;
	localparam logic [15:0] OP_BANK_HI   = 16'b1011_101?_????_????;
	localparam logic [15:0] OP_MUL_LIT   = 16'hBC??;
	localparam logic [15:0] OP_CALL      = 16'b111?_????_????_????;
	localparam logic [15:0] OP_GOTO      = 16'b110?_????_????_????;
	localparam logic [15:0] OP_ADD_FILE  = 16'b0000_111?_????_????;
	localparam logic [15:0] OP_ADD_CARRY = 16'b0001_000?_????_????;
	localparam logic [15:0] OP_AND_FILE  = 16'b0000_101?_????_????;
	localparam logic [15:0] OP_XOR_FILE  = 16'b0000_110?_????_????;
	localparam logic [15:0] OP_SKIP_ZERO = 16'h33??;
	localparam logic [15:0] OP_BIT_CLR   = 16'b1000_1???_????_????;
	localparam logic [15:0] OP_BIT_SET   = 16'b1000_0???_????_????;
	localparam logic [15:0] OP_SKIP_LOW  = 16'b1001_1???_????_????;
	localparam logic [15:0] OP_SKIP_HIGH = 16'b1001_0???_????_????;
	localparam logic [15:0] OP_BIT_INV   = 16'b0011_1???_????_????;
	localparam logic [15:0] OP_CLRF   = 16'b0010_100?_????_????;
	localparam logic [15:0] OP_SETF   = 16'b0010_101?_????_????;
	localparam logic [15:0] OP_NEGW   = 16'b0010_110?_????_????;
	localparam logic [15:0] OP_DAW    = 16'b0010_111?_????_????;
	localparam logic [15:0] OP_TBL_RD = 16'b1010_10??_????_????;
	localparam logic [15:0] OP_TBL_WR = 16'b1010_11??_????_????;

endpackage

// ### hw/mcu_instruction_decoder.sv
// Instruction decode and execute core with AXI4-Lite access to its state.
//
// Design decisions made here: register access over AXI4-Lite and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module mcu_instruction_decoder
	import mcu_decoder_pkg::*;
#(
	parameter int         STACK_DEPTH   = 16,
	parameter logic [7:0] PC_LOW_FILE_ADDR = 8'h02
) (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	input  wire logic        instr_valid,
	input  wire logic [15:0] instr,
	output logic             instr_ready,
	output logic [15:0]      pc_addr,
	output logic [7:0]       file_addr,
	output logic [7:0]       bank_sel,
	output logic             file_rd_en,
	input  wire logic [7:0]  file_rd_data,
	output logic             file_wr_en,
	output logic [7:0]       file_wr_data,
	input  wire logic        tbl_internal,
	input  wire logic        irq_event
);

	localparam int SPW = $clog2(STACK_DEPTH);

	q_phase_t    phase;
	exec_state_t state_q;
	logic        run_q;
	logic [7:0]  acc_q;
	logic [7:0]  bank_q;
	logic [7:0]  lath_q;
	logic [7:0]  opnd_q;
	logic [7:0]  res_q;
	logic [15:0] ir_q;
	logic [15:0] pc_q;
	logic [15:0] prod_q;
	flags_t      flags_q;
	logic        irq_dis_q;
	logic        irq_dis_clr_q;
	logic        irq_seen_q;
	logic [1:0]  nop_left_q;
	logic [15:0] stack_q [STACK_DEPTH];
	logic [SPW-1:0] sp_q;

	alu_op_t     alu_op;
	logic [7:0]  alu_a;
	logic [7:0]  alu_b;
	logic        alu_cin;
	logic [7:0]  alu_y;
	flags_t      alu_fl;
	flags_t      upd;
	logic        wr_acc;
	logic        wr_file;
	logic        skip;
	logic        push;
	logic        pop;
	logic        ld_pc;
	logic        ld_lath;
	logic        mul;
	logic        ret_irq;
	logic        prog;
	logic        bank_lo;
	logic        bank_hi;
	logic [1:0]  extra;
	logic [15:0] pc_tgt;
	logic [7:0]  lath_tgt;
	logic [8:0]  daw_v;
	logic [7:0]  bit_m;
	logic        commit;
	logic        take;

	logic        aw_q;
	logic        w_q;
	logic [7:0]  awaddr_q;
	logic [31:0] wdata_q;
	logic [3:0]  wstrb_q;
	logic        do_wr;
	logic        sw_wr;
	logic [31:0] rd_mux;
	logic        rd_hit;

	function automatic logic reg_hit(input logic [7:0] addr, input logic [7:0] ofs);
		return addr[7:2] == ofs[7:2];
	endfunction

	function automatic logic [8:0] dec_adjust(input logic [7:0] v, input logic c, input logic hc);
		logic [8:0] t;
		t = {1'b0, v};
		if (hc || (t[3:0] > 4'h9)) begin
			t = t + 9'h006;
		end
		if (c || t[8] || (t[7:4] > 4'h9)) begin
			t = t + 9'h060;
		end
		t[8] = t[8] | c;
		return t;
	endfunction

	q_phase_gen u_phase (
		.aclk    (aclk),
		.aresetn (aresetn),
		.phase   (phase)
	);

	mcu_alu u_alu (
		.a   (alu_a),
		.b   (alu_b),
		.cin (alu_cin),
		.op  (alu_op),
		.y   (alu_y),
		.fl  (alu_fl)
	);

	assign instr_ready  = run_q && (state_q == ST_EXEC) && (phase == PH_DECODE);
	assign take         = instr_ready && instr_valid;
	assign commit       = (phase == PH_WRITE);
	assign pc_addr      = pc_q;
	assign file_addr    = ir_q[7:0];
	assign bank_sel     = bank_q;
	assign file_rd_en   = (phase == PH_READ);
	assign file_wr_en   = commit && wr_file;
	assign file_wr_data = res_q;
	assign bit_m        = 8'h01 << ir_q[10:8];
	assign daw_v        = dec_adjust(acc_q, flags_q.c, flags_q.hc);

	// Decode works on the latched word; forced NOP cycles load an all-zero word.
	always_comb begin
		alu_op   = ALU_PASS;
		alu_a    = acc_q;
		alu_b    = opnd_q;
		alu_cin  = 1'b0;
		upd      = '0;
		wr_acc   = 1'b0;
		wr_file  = 1'b0;
		skip     = 1'b0;
		push     = 1'b0;
		pop      = 1'b0;
		ld_pc    = 1'b0;
		ld_lath  = 1'b0;
		mul      = 1'b0;
		ret_irq  = 1'b0;
		prog     = 1'b0;
		bank_lo  = 1'b0;
		bank_hi  = 1'b0;
		extra    = 2'h0;
		pc_tgt   = {pc_q[15:13], ir_q[12:0]};
		lath_tgt = {pc_q[15:13], ir_q[12:8]};
		casez (ir_q)
			OP_ADD_LIT: begin
				alu_op = ALU_ADD;
				alu_b  = ir_q[7:0];
				wr_acc = 1'b1;
				upd    = '1;
			end
			OP_ADD_FILE, OP_ADD_CARRY: begin
				alu_op  = ALU_ADD;
				alu_cin = ir_q[12] & flags_q.c;
				wr_acc  = !ir_q[8];
				wr_file = ir_q[8];
				upd     = '1;
			end
			OP_AND_LIT, OP_OR_LIT, OP_XOR_LIT: begin
				alu_op = (ir_q[10:8] == 3'h5) ? ALU_AND :
					(ir_q[10:8] == 3'h3) ? ALU_OR : ALU_XOR;
				alu_b  = ir_q[7:0];
				wr_acc = 1'b1;
				upd.z  = 1'b1;
			end
			OP_AND_FILE, OP_XOR_FILE: begin
				alu_op  = ir_q[9] ? ALU_AND : ALU_XOR;
				wr_acc  = !ir_q[8];
				wr_file = ir_q[8];
				upd.z   = 1'b1;
			end
			OP_LIT_SUB: begin
				alu_op = ALU_SUB;
				alu_a  = ir_q[7:0];
				alu_b  = acc_q;
				wr_acc = 1'b1;
				upd    = '1;
			end
			OP_LOAD_LIT: begin
				alu_b  = ir_q[7:0];
				wr_acc = 1'b1;
			end
			OP_MUL_LIT: mul = 1'b1;
			OP_BIT_CLR, OP_BIT_SET, OP_BIT_INV: begin
				alu_b   = ir_q[15] ? (ir_q[11] ? (opnd_q & ~bit_m) : (opnd_q | bit_m))
					: (opnd_q ^ bit_m);
				wr_file = 1'b1;
			end
			OP_SKIP_LOW: skip = !opnd_q[ir_q[10:8]];
			OP_SKIP_HIGH: skip = opnd_q[ir_q[10:8]];
			OP_SKIP_ZERO: skip = (opnd_q == 8'h00);
			OP_CLRF, OP_SETF, OP_NEGW, OP_DAW: begin
				wr_file = 1'b1;
				wr_acc  = !ir_q[8];
				case (ir_q[10:9])
					2'b00: alu_b = 8'h00;
					2'b01: alu_b = 8'hFF;
					2'b10: begin
						alu_op = ALU_SUB;
						alu_a  = 8'h00;
						alu_b  = acc_q;
						upd    = '1;
					end
					default: begin
						alu_b   = daw_v[7:0];
						alu_cin = daw_v[8];
						upd.c   = 1'b1;
					end
				endcase
			end
			OP_BANK_LO: bank_lo = 1'b1;
			OP_BANK_HI: bank_hi = 1'b1;
			OP_CALL, OP_GOTO: begin
				push    = ir_q[13];
				ld_pc   = 1'b1;
				ld_lath = 1'b1;
				extra   = NOPS_BRANCH;
			end
			OP_LONG_CALL: begin
				push   = 1'b1;
				ld_pc  = 1'b1;
				pc_tgt = {lath_q, ir_q[7:0]};
				extra  = NOPS_BRANCH;
			end
			OP_RETURN, OP_IRQ_RET, OP_RET_LIT: begin
				pop     = 1'b1;
				ld_pc   = 1'b1;
				pc_tgt  = stack_q[sp_q - 1'b1];
				ret_irq = (ir_q == OP_IRQ_RET);
				alu_b   = ir_q[7:0];
				wr_acc  = ir_q[15];
				extra   = NOPS_BRANCH;
			end
			OP_TBL_RD: extra = (ir_q[7:0] == PC_LOW_FILE_ADDR) ? NOPS_TBL_PC_LOW : NOPS_BRANCH;
			OP_TBL_WR: begin
				prog  = tbl_internal;
				extra = NOPS_BRANCH;
			end
			default: begin
			end
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ir_q   <= OP_NOP;
			opnd_q <= 8'h00;
			res_q  <= 8'h00;
		end else begin
			if (phase == PH_DECODE) begin
				ir_q <= take ? instr : OP_NOP;
			end
			if (phase == PH_READ) begin
				opnd_q <= file_rd_data;
			end
			if (phase == PH_PROCESS) begin
				res_q <= alu_y;
			end
		end
	end

	// Each forced cycle after a branch, skip or table access runs as a full NOP.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_q    <= ST_EXEC;
			nop_left_q <= 2'h0;
		end else if (commit) begin
			case (state_q)
				ST_EXEC: begin
					if (prog) begin
						state_q <= ST_PROG;
					end else if (skip) begin
						state_q    <= ST_NOP;
						nop_left_q <= NOPS_SKIP;
					end else if (extra != 2'h0) begin
						state_q    <= ST_NOP;
						nop_left_q <= extra;
					end
				end
				ST_NOP: begin
					nop_left_q <= nop_left_q - 2'h1;
					if (nop_left_q == 2'h1) begin
						state_q <= ST_EXEC;
					end
				end
				ST_PROG: begin
					if (irq_seen_q || irq_event) begin
						state_q <= ST_EXEC;
					end
				end
				default: state_q <= ST_EXEC;
			endcase
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq_seen_q <= 1'b0;
		end else if (state_q != ST_PROG) begin
			irq_seen_q <= 1'b0;
		end else if (irq_event) begin
			irq_seen_q <= 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pc_q <= PC_RST;
		end else if (sw_wr && reg_hit(awaddr_q, REG_PC)) begin
			if (wstrb_q[0]) pc_q[7:0] <= wdata_q[7:0];
			if (wstrb_q[1]) pc_q[15:8] <= wdata_q[15:8];
		end else if (take) begin
			pc_q <= pc_q + 16'h0001;
		end else if (commit) begin
			if (ld_pc) begin
				pc_q <= pc_tgt;
			end else if (skip) begin
				pc_q <= pc_q + 16'h0001;
			end else if (wr_file && (ir_q[7:0] == PC_LOW_FILE_ADDR)) begin
				pc_q <= {lath_q, res_q};
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sp_q <= '0;
		end else if (commit && push) begin
			stack_q[sp_q] <= pc_q;
			sp_q          <= sp_q + 1'b1;
		end else if (commit && pop) begin
			sp_q <= sp_q - 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			lath_q <= LATH_RST;
		end else if (sw_wr && reg_hit(awaddr_q, REG_PC) && wstrb_q[2]) begin
			lath_q <= wdata_q[23:16];
		end else if (commit && ld_lath) begin
			lath_q <= lath_tgt;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			acc_q <= ACC_RST;
		end else if (sw_wr && reg_hit(awaddr_q, REG_ACC) && wstrb_q[0]) begin
			acc_q <= wdata_q[7:0];
		end else if (commit && wr_acc) begin
			acc_q <= res_q;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			flags_q <= FLAGS_RST;
		end else if (sw_wr && reg_hit(awaddr_q, REG_STATUS) && wstrb_q[0]) begin
			flags_q <= wdata_q[3:0];
		end else if (commit) begin
			flags_q <= (alu_fl & upd) | (flags_q & ~upd);
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bank_q <= BANK_RST;
		end else if (sw_wr && reg_hit(awaddr_q, REG_BANK) && wstrb_q[0]) begin
			bank_q <= wdata_q[7:0];
		end else if (commit && bank_lo) begin
			bank_q[3:0] <= ir_q[3:0];
		end else if (commit && bank_hi) begin
			bank_q[7:4] <= ir_q[7:4];
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			prod_q <= 16'h0000;
		end else if (commit && mul) begin
			prod_q <= 16'(acc_q) * 16'(ir_q[7:0]);
		end
	end

	// The enable is released in the next first phase so a read-modify-write cannot undo it.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq_dis_q     <= IRQ_DIS_RST;
			irq_dis_clr_q <= 1'b0;
		end else begin
			if (commit && ret_irq) begin
				irq_dis_clr_q <= 1'b1;
			end else if (phase == PH_DECODE) begin
				irq_dis_clr_q <= 1'b0;
			end
			if (phase == PH_DECODE && irq_dis_clr_q) begin
				irq_dis_q <= 1'b0;
			end else if (sw_wr && reg_hit(awaddr_q, REG_STATUS) && wstrb_q[0]) begin
				irq_dis_q <= wdata_q[STAT_IRQ_DIS];
			end
		end
	end

	// Software writes to core state other than the run bit in REG_CTRL land only while the core is stopped.
	assign s_axi_awready = !aw_q && !s_axi_bvalid;
	assign s_axi_wready  = !w_q && !s_axi_bvalid;
	assign do_wr         = aw_q && w_q && !s_axi_bvalid;
	assign sw_wr         = do_wr && !run_q;
	assign s_axi_arready = !s_axi_rvalid;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_q         <= 1'b0;
			w_q          <= 1'b0;
			awaddr_q     <= 8'h00;
			wdata_q      <= 32'h0000_0000;
			wstrb_q      <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= RESP_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_q     <= 1'b1;
				awaddr_q <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_q     <= 1'b1;
				wdata_q <= s_axi_wdata;
				wstrb_q <= s_axi_wstrb;
			end
			if (do_wr) begin
				aw_q         <= 1'b0;
				w_q          <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= (awaddr_q > REG_BANK + 8'h03) ? RESP_SLVERR : RESP_OKAY;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			run_q <= RUN_RST;
		end else if (do_wr && reg_hit(awaddr_q, REG_CTRL) && wstrb_q[0]) begin
			run_q <= wdata_q[0];
		end
	end

	always_comb begin
		rd_mux = 32'h0000_0000;
		rd_hit = 1'b1;
		if (reg_hit(s_axi_araddr, REG_CTRL)) begin
			rd_mux[0] = run_q;
		end else if (reg_hit(s_axi_araddr, REG_ACC)) begin
			rd_mux[7:0] = acc_q;
		end else if (reg_hit(s_axi_araddr, REG_STATUS)) begin
			rd_mux[3:0]         = flags_q;
			rd_mux[STAT_IRQ_DIS] = irq_dis_q;
			rd_mux[STAT_PROG]   = (state_q == ST_PROG);
		end else if (reg_hit(s_axi_araddr, REG_PC)) begin
			rd_mux[23:0] = {lath_q, pc_q};
		end else if (reg_hit(s_axi_araddr, REG_BANK)) begin
			rd_mux[7:0] = bank_q;
		end else if (reg_hit(s_axi_araddr, REG_PROD)) begin
			rd_mux[15:0] = prod_q;
		end else begin
			rd_hit = 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h0000_0000;
			s_axi_rresp  <= RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata  <= rd_mux;
			s_axi_rresp  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

endmodule
`default_nettype wire

// ### hw/q_phase_gen.sv
// Four-phase sequencer that splits each instruction cycle into oscillator phases.
`timescale 1ns/1ps
`default_nettype none
module q_phase_gen
	import mcu_decoder_pkg::*;
(
	input  wire logic aclk,
	input  wire logic aresetn,
	output q_phase_t  phase
);

	q_phase_t phase_q;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			phase_q <= PH_DECODE;
		end else begin
			phase_q <= q_phase_t'(phase_q + 2'b01);
		end
	end

	assign phase = phase_q;

endmodule
`default_nettype wire

// ### tb/mcu_instruction_decoder_chk.sv
// Port assertions for the instruction decoder, bound to its top module.
`timescale 1ns/1ps
`default_nettype none
module mcu_instruction_decoder_chk (
	input wire logic        aclk,
	input wire logic        aresetn,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wready,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic        instr_valid,
	input wire logic [15:0] instr,
	input wire logic        instr_ready,
	input wire logic        file_rd_en,
	input wire logic        file_wr_en,
	input wire logic [7:0]  file_addr,
	input wire logic [7:0]  bank_sel
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	sequence take_s;
		instr_valid && instr_ready;
	endsequence
	sequence bank_lo_s;
		take_s ##0 instr[15:8] == 8'hB8;
	endsequence
	sequence branch_s;
		take_s ##0 instr[15:14] == 2'b11;
	endsequence
	ready_once_a: assert property (instr_ready |=> !instr_ready [*3])
		else $error("fetch offered twice in one cycle");
	read_phase_a: assert property (instr_ready |=> file_rd_en ##1 !file_rd_en)
		else $error("file read not in second phase");
	write_phase_a: assert property (file_wr_en |-> $past(file_rd_en, 2) && !$past(file_wr_en))
		else $error("file write not in last phase");
	addr_stands_a: assert property (file_wr_en |-> file_addr == $past(file_addr, 2))
		else $error("file address moved inside a cycle");
	bank_low_a: assert property (bank_lo_s |-> ##4 bank_sel[3:0] == $past(instr[3:0], 4))
		else $error("bank low nibble not loaded");
	branch_nop_a: assert property (branch_s |=> !instr_ready [*7])
		else $error("branch did not add a second cycle");
	b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("write response dropped early");
	r_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
		else $error("read answer late");
	b_follow_a: assert property ($rose(s_axi_bvalid) |-> !$past(s_axi_awready) && !$past(s_axi_wready))
		else $error("write response before address and data");
endmodule
bind mcu_instruction_decoder mcu_instruction_decoder_chk u_chk (.aclk(aclk), .aresetn(aresetn),
	.s_axi_awready(s_axi_awready), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
	.s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
	.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .instr_valid(instr_valid), .instr(instr),
	.instr_ready(instr_ready), .file_rd_en(file_rd_en), .file_wr_en(file_wr_en), .file_addr(file_addr),
	.bank_sel(bank_sel));
`default_nettype wire

// ### tb/test_mcu_instruction_decoder.sv
// Self-checking bench for the instruction decoder.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin miscompares++; \
	$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module test_mcu_instruction_decoder
	import mcu_decoder_pkg::*;
;
	logic        aclk;
	logic        aresetn = 0, awv = 0, wv = 0, bready = 0, arv = 0, rready = 0, iv = 0, tint = 0, irqe = 0;
	logic [7:0]  awa = 0, ara = 0, frd = 0, a, k, y, ea, lwr, m;
	logic [3:0]  ws = 4'hF, ef = 4'h0;
	logic [31:0] wd = 0, rdv, rdat;
	logic [15:0] ins = 0, tpc, pca;
	logic [1:0]  br, rr;
	logic [7:0]  fa, bs, fwd;
	logic        awr, wrdy, bv, arr, rv, ir, fre, fwe, d;
	logic [2:0]  b;
	int          seed = 35, n, j, nwr, gap, total_checks = 0, miscompares = 0;
	time         tprev = 0;
	logic [7:0]  lop [7] = '{8'hB1, 8'hB2, 8'hB3, 8'hB4, 8'hB5, 8'hB0, 8'hBC};
	int          lsel [7] = '{0, 1, 3, 4, 2, 5, 5};
	logic [6:0]  fop [4] = '{7'h07, 7'h08, 7'h05, 7'h06};
	int          fsel [4] = '{0, 0, 2, 4};
	logic [4:0]  bo [3] = '{5'h11, 5'h10, 5'h07};
	logic [4:0]  sk [3] = '{5'h06, 5'h13, 5'h12};
	logic [15:0] bw [9] = '{16'hB734, 16'hC123, 16'hE200, 16'hB677, 16'hE300, 16'h0005, 16'hAC50, 0, 0};
	logic [15:0] bp [9] = '{0, 16'h5A34, 16'h4123, 16'h4200, 16'h4124, 16'h4300, 16'h4125, 16'h4126, 16'h4127};
	int          bg [9] = '{0, 8, 8, 8, 8, 8, 8, 8, 4};
	logic [7:0]  ra [5] = '{REG_CTRL, REG_ACC, REG_STATUS, REG_PC, REG_BANK};

	mcu_instruction_decoder u_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
		.s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv), .s_axi_wready(wrdy),
		.s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bready), .s_axi_araddr(ara), .s_axi_arvalid(arv),
		.s_axi_arready(arr), .s_axi_rdata(rdat), .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rready),
		.instr_valid(iv), .instr(ins), .instr_ready(ir), .pc_addr(pca), .file_addr(fa), .bank_sel(bs),
		.file_rd_en(fre), .file_rd_data(frd), .file_wr_en(fwe), .file_wr_data(fwd), .tbl_internal(tint),
		.irq_event(irqe));

	initial begin
		aclk = 0;
		forever #5 aclk = ~aclk;
	end

	always @(posedge aclk) if (fwe === 1'b1) begin
		nwr++;
		lwr = fwd;
	end

	// Carry is the inverse of borrow when subtracting, as for the add path.
	function automatic logic [11:0] alu_ref(input int op, input logic [7:0] x, z, input logic c, input logic [3:0] fo);
		logic [8:0] s;
		logic [4:0] h;
		h = 5'h00;
		case (op)
			0: begin s = x + z + c; h = x[3:0] + z[3:0] + c; end
			1: begin s = {1'b0, z} + {1'b0, ~x} + 9'h001; h = z[3:0] + {1'b0, ~x[3:0]} + 5'h01; end
			2: s = x & z;
			3: s = x | z;
			default: s = x ^ z;
		endcase
		if (op < 2) return {s[7:0], (x[7] ^ (op == 1)) == z[7] && s[7] != z[7], s[7:0] == 0, h[4], s[8]};
		return {s[7:0], fo[3], s[7:0] == 0, fo[1:0]};
	endfunction

	task automatic test_done;
		$display("checks %0d mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask

	task automatic tmo(input int i);
		if (i >= 60) begin miscompares++; test_done(); end
	endtask

	task automatic axw(input logic [7:0] ad, input logic [31:0] dt, input logic [1:0] er);
		int i;
		@(posedge aclk);
		awa <= ad;
		wd <= dt;
		awv <= 1'b1;
		wv <= 1'b1;
		for (i = 0; i < 60; i++) begin
			@(posedge aclk);
			if (awr === 1'b1) awv <= 1'b0;
			if (wrdy === 1'b1) wv <= 1'b0;
			if (bv === 1'b1) break;
		end
		tmo(i);
		`CHK(br, er)
		bready <= 1'b1;
		@(posedge aclk);
		bready <= 1'b0;
	endtask

	// The pause lets the instruction in flight finish its write before the read.
	task automatic axr(input logic [7:0] ad, input logic [1:0] er);
		int i;
		repeat (4) @(posedge aclk);
		ara <= ad;
		arv <= 1'b1;
		rready <= 1'b1;
		for (i = 0; i < 60; i++) begin
			@(posedge aclk);
			if (arr === 1'b1) arv <= 1'b0;
			if (rv === 1'b1) break;
		end
		tmo(i);
		rdv = rdat;
		rready <= 1'b0;
		`CHK(rr, er)
	endtask

	task automatic ex(input logic [15:0] w, input logic [7:0] f);
		int i;
		@(posedge aclk);
		ins <= w;
		frd <= f;
		iv <= 1'b1;
		for (i = 0; i < 60; i++) begin
			@(posedge aclk);
			if (ir === 1'b1) break;
		end
		tmo(i);
		iv <= 1'b0;
		gap = ($time - tprev) / 10;
		tprev = $time;
		tpc = pca;
	endtask

	initial begin
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		for (n = 0; n < 5; n++) begin
			axr(ra[n], RESP_OKAY);
			`CHK(rdv, (n == 2) ? 32'h10 : 32'h0)
		end
		axr(8'h20, RESP_SLVERR);
		`CHK(rdv, 32'h0)
		axw(8'h18, 32'h0, RESP_SLVERR);
		ws <= 4'h0;
		axw(REG_ACC, 32'h99, RESP_OKAY);
		ws <= 4'hF;
		axr(REG_ACC, RESP_OKAY);
		`CHK(rdv, 32'h0)
		axw(REG_ACC, 32'h10, RESP_OKAY);
		axw(REG_PC, 32'h005A0000, RESP_OKAY);
		axr(REG_PC, RESP_OKAY);
		`CHK(rdv, 32'h005A0000)
		axw(REG_CTRL, 32'h1, RESP_OKAY);
		for (n = 0; n < 9; n++) begin
			ex(bw[n], 8'h00);
			if (n > 0) `CHK({tpc, 16'(gap)}, {bp[n], 16'(bg[n])})
		end
		axr(REG_STATUS, RESP_OKAY);
		`CHK(rdv[4], 1'b0)
		ex(16'hB110, 8'h00);
		axw(REG_ACC, 32'hEE, RESP_OKAY);
		axr(REG_ACC, RESP_OKAY);
		`CHK(rdv[7:0], 8'h87)
		{y, ef} = alu_ref(0, 8'h77, 8'h10, 1'b0, ef);
		for (n = 0; n < 35; n++) begin
			j = n % 7;
			a = 8'($random(seed));
			k = (n == 8) ? a : 8'($random(seed));
			ex({8'hB0, a}, 8'h00);
			ex({lop[j], k}, 8'h00);
			if (j < 5) {ea, ef} = alu_ref(lsel[j], a, k, 1'b0, ef);
			else ea = (j == 5) ? k : a;
			axr(REG_ACC, RESP_OKAY);
			`CHK(rdv[7:0], ea)
			axr(REG_STATUS, RESP_OKAY);
			`CHK(rdv[3:0], ef)
			if (j == 6) axr(REG_PROD, RESP_OKAY);
			if (j == 6) `CHK(rdv[15:0], 16'(a) * 16'(k))
		end
		for (n = 0; n < 24; n++) begin
			j = n % 4;
			a = 8'($random(seed));
			k = 8'($random(seed));
			d = 1'($random(seed));
			ex({8'hB0, a}, 8'h00);
			nwr = 0;
			ex({fop[j], d, 8'h40}, k);
			{y, ef} = alu_ref(fsel[j], a, k, (j == 1) & ef[0], ef);
			axr(REG_ACC, RESP_OKAY);
			`CHK(rdv[7:0], d ? a : y)
			axr(REG_STATUS, RESP_OKAY);
			`CHK({rdv[3:0], 8'(nwr)}, {ef, 7'h00, d})
			if (d) `CHK(lwr, y)
		end
		for (n = 0; n < 12; n++) begin
			j = n % 3;
			b = 3'($random(seed));
			k = 8'($random(seed));
			m = 8'h01 << b;
			y = (j == 0) ? (k & ~m) : (j == 1) ? (k | m) : (k ^ m);
			nwr = 0;
			ex({bo[j], b, 8'h41}, k);
			axr(REG_STATUS, RESP_OKAY);
			`CHK({rdv[3:0], 8'(nwr), lwr}, {ef, 8'h01, y})
		end
		for (n = 0; n < 4; n++) begin
			ex(16'hB05A, 8'h00);
			ex({6'b001010, n[1], n[0], 8'h44}, 8'h33);
			axr(REG_ACC, RESP_OKAY);
			`CHK({rdv[7:0], lwr}, {n[0] ? 8'h5A : {8{n[1]}}, {8{n[1]}}})
		end
		ex(16'hB8A5, 8'h00);
		ex(16'hBAC0, 8'h00);
		axr(REG_BANK, RESP_OKAY);
		`CHK({rdv[7:0], bs}, 16'hC5C5)
		for (n = 0; n < 18; n++) begin
			j = n % 3;
			b = 3'($random(seed));
			k = (n % 2) ? 8'h00 : 8'($random(seed));
			d = (j == 0) ? (k == 0) : (k[b] ^ (j == 1));
			ex({sk[j], (j == 0) ? 3'd3 : b, 8'h43}, k);
			ex(16'h0000, 8'h00);
			`CHK(gap, d ? 8 : 4)
		end
		for (n = 0; n < 2; n++) begin
			ex({8'hA8, n[0] ? 8'h02 : 8'h03}, 8'h00);
			ex(16'h0000, 8'h00);
			`CHK(gap, n[0] ? 12 : 8)
		end
		tint <= 1'b1;
		ex(16'hAC50, 8'h00);
		axr(REG_STATUS, RESP_OKAY);
		`CHK(rdv[5], 1'b1)
		irqe <= 1'b1;
		@(posedge aclk);
		irqe <= 1'b0;
		tint <= 1'b0;
		ex(16'h0000, 8'h00);
		axr(REG_STATUS, RESP_OKAY);
		`CHK(rdv[5], 1'b0)
		test_done();
	end
endmodule
`default_nettype wire
